// ---- common/sid_defines.svh ----
`ifndef SID_DEFINES_SVH
`define SID_DEFINES_SVH

// Instruction register
`define SID_IR_WIDTH 8
`define SID_IR_RESET 8'hFF
`define SID_IR_STATUS 8'h81

// Instruction codes, parity bit in bit 7
`define SID_IR_EXTEST 8'h00
`define SID_IR_SAMPLE 8'h82
`define SID_IR_INTEST 8'h03
`define SID_IR_HIGHZ 8'h06
`define SID_IR_CLAMP 8'h87
`define SID_IR_RUN 8'h09
`define SID_IR_READ_NORMAL 8'h0A
`define SID_IR_READ_TEST 8'h8B
`define SID_IR_CELL_CHECK 8'h0C
`define SID_IR_TOGGLE_ONLY 8'h8D
`define SID_IR_CTRL_SCAN_NORMAL 8'h8E
`define SID_IR_CTRL_SCAN_TEST 8'h0F

// Run-test control register layout
`define SID_CTRL_WIDTH 11
`define SID_CTRL_RESET 11'h002
`define SID_MASK_HI 10
`define SID_MASK_LO 3
`define SID_MASK_WIDTH 8
`define SID_OPSEL_HI 2
`define SID_OPSEL_LO 0

// Operation select codes, bit 2 ignored for the first three
`define SID_OPSEL_SAMPLE_TOGGLE 2'h0
`define SID_OPSEL_PATTERN 2'h1
`define SID_OPSEL_SIGNATURE 2'h2
`define SID_OPSEL_SIG_PATTERN 3'h3
`define SID_OPSEL_SIG_COUNT 3'h7

// Bypass capture value
`define SID_BYPASS_CAPT 1'h0

// Crossing word width: dreg 3, mode 3, capture 3, op 7, mask 8
`define SID_WORD_WIDTH 24

`endif

// ---- common/sid_pkg.sv ----
package sid_pkg;

typedef enum logic [2:0] {
    SID_DREG_BOUNDARY = 3'h1,
    SID_DREG_BYPASS = 3'h2,
    SID_DREG_CONTROL = 3'h4
} sid_dreg_e;

typedef enum logic [2:0] {
    SID_MODE_NORMAL = 3'h1,
    SID_MODE_TEST = 3'h2,
    SID_MODE_MODTEST = 3'h4
} sid_mode_e;

typedef enum logic [2:0] {
    SID_CAPT_SAMPLE = 3'h1,
    SID_CAPT_HOLD = 3'h2,
    SID_CAPT_INVERT = 3'h4
} sid_capt_e;

typedef enum logic [6:0] {
    SID_OP_IDLE = 7'h01,
    SID_OP_SAMPLE_TOGGLE = 7'h02,
    SID_OP_PATTERN = 7'h04,
    SID_OP_SIGNATURE = 7'h08,
    SID_OP_SIG_PATTERN = 7'h10,
    SID_OP_SIG_COUNT = 7'h20,
    SID_OP_TOGGLE_OUT = 7'h40
} sid_runop_e;

endpackage

// ---- hdl/sid_scan_stage.sv ----
`timescale 1ns/1ns
`default_nettype none

module sid_scan_stage #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter logic [WIDTH-1:0] CAPT_VAL = '0,
    parameter bit CAPT_KEEP = 1'b0
) (
    // Test clock and resets
    input wire logic tck,
    input wire logic rst_n,
    input wire logic testLogicReset,
    // Scan strobes for this register
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic tdi,
    // Shift stage and shadow latch
    output logic [WIDTH-1:0] shiftQ,
    output logic [WIDTH-1:0] shadowQ
);

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            shiftQ <= RESET_VAL;
        end else if (testLogicReset) begin
            shiftQ <= RESET_VAL;
        end else if (capture && !CAPT_KEEP) begin
            shiftQ <= CAPT_VAL;
        end else if (shift) begin
            // Enters at the top bit, leaves from bit 0
            shiftQ <= {tdi, shiftQ[WIDTH-1:1]};
        end
    end

    // Shadow moves on the falling edge so decode never sees a half-shifted value
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            shadowQ <= RESET_VAL;
        end else if (testLogicReset) begin
            shadowQ <= RESET_VAL;
        end else if (update) begin
            shadowQ <= shiftQ;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/sid_word_cross.sv ----
`timescale 1ns/1ns
`default_nettype none

module sid_word_cross #(
    parameter int WIDTH = 24
) (
    // Test clock side
    input wire logic tck,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] wordIn,
    // System clock side
    input wire logic clk,
    input wire logic clkEn,
    output logic [WIDTH-1:0] wordOut
);

    logic [WIDTH-1:0] heldQ;
    logic toggleQ;
    logic [2:0] syncQ;
    logic seenQ;

    // Held word only moves with the toggle, so it is quiet while the far side samples it.
    // Limitation: changes closer than about five system clocks apart are merged.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            heldQ <= '0;
            toggleQ <= 1'b0;
        end else if (wordIn != heldQ) begin
            heldQ <= wordIn;
            toggleQ <= ~toggleQ;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncQ <= 3'h0;
        end else if (clkEn) begin
            syncQ <= {syncQ[1:0], toggleQ};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seenQ <= 1'b0;
            wordOut <= '0;
        end else if (clkEn && syncQ[1] == syncQ[2] && syncQ[2] != seenQ) begin
            seenQ <= syncQ[2];
            wordOut <= heldQ;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/sid_scan_decode.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sid_defines.svh"

module sid_scan_decode
    import sid_pkg::*;
(
    // System clock side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Test access pins
    input wire logic tck,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOeN,
    // Controller state strobes, test clock domain
    input wire logic testLogicReset,
    input wire logic runTestIdle,
    input wire logic captureDr,
    input wire logic shiftDr,
    input wire logic updateDr,
    input wire logic captureIr,
    input wire logic shiftIr,
    input wire logic updateIr,
    // Boundary chain link
    input wire logic boundaryChainOut,
    input wire logic aSideDriveEnable,
    input wire logic bSideDriveEnable,
    // Decoded controls, test clock domain
    output sid_dreg_e selReg,
    output sid_mode_e modeSel,
    output sid_capt_e cellCapture,
    output sid_runop_e runOp,
    output logic [`SID_MASK_WIDTH-1:0] inputExclude,
    // Decoded controls, system clock domain
    output sid_dreg_e sysSelReg,
    output sid_mode_e sysMode,
    output sid_capt_e sysCapture,
    output sid_runop_e sysRunOp,
    output logic [`SID_MASK_WIDTH-1:0] sysInputExclude
);

    logic [`SID_IR_WIDTH-1:0] irShift;
    logic [`SID_IR_WIDTH-1:0] irShadow;
    logic [`SID_CTRL_WIDTH-1:0] ctrlShift;
    logic [`SID_CTRL_WIDTH-1:0] ctrlShadow;
    logic bypassQ;
    sid_dreg_e dregD;
    sid_mode_e modeD;
    sid_capt_e captD;
    sid_runop_e runOpD;
    logic selCtrl;
    logic selBypass;
    logic dirValid;
    logic [`SID_WORD_WIDTH-1:0] sysWord;
    logic [`SID_CTRL_WIDTH-1:0] ctrlPrevQ;
    logic tdiPrevQ;

    assign selCtrl = (selReg == SID_DREG_CONTROL);
    assign selBypass = (selReg == SID_DREG_BYPASS);
    assign dirValid = (aSideDriveEnable != bSideDriveEnable);

    // Instruction register; parity is trusted, not checked
    sid_scan_stage #(
        .WIDTH(`SID_IR_WIDTH),
        .RESET_VAL(`SID_IR_RESET),
        .CAPT_VAL(`SID_IR_STATUS),
        .CAPT_KEEP(1'b0)
    ) irStage (
        .tck(tck),
        .rst_n(rst_n),
        .testLogicReset(testLogicReset),
        .capture(captureIr),
        .shift(shiftIr),
        .update(updateIr),
        .tdi(tdi),
        .shiftQ(irShift),
        .shadowQ(irShadow)
    );

    // Run-test control register keeps its value at capture
    sid_scan_stage #(
        .WIDTH(`SID_CTRL_WIDTH),
        .RESET_VAL(`SID_CTRL_RESET),
        .CAPT_VAL(`SID_CTRL_RESET),
        .CAPT_KEEP(1'b1)
    ) ctrlStage (
        .tck(tck),
        .rst_n(rst_n),
        .testLogicReset(testLogicReset),
        .capture(captureDr && selCtrl),
        .shift(shiftDr && selCtrl),
        .update(updateDr && selCtrl),
        .tdi(tdi),
        .shiftQ(ctrlShift),
        .shadowQ(ctrlShadow)
    );

    // Instruction decode of the value about to be latched
    always_comb begin
        dregD = SID_DREG_BYPASS;
        modeD = SID_MODE_NORMAL;
        captD = SID_CAPT_SAMPLE;
        case (irShift)
            `SID_IR_EXTEST, `SID_IR_INTEST: begin
                dregD = SID_DREG_BOUNDARY;
                modeD = SID_MODE_TEST;
            end
            `SID_IR_SAMPLE: begin
                dregD = SID_DREG_BOUNDARY;
            end
            `SID_IR_HIGHZ: begin
                modeD = SID_MODE_MODTEST;
            end
            `SID_IR_CLAMP, `SID_IR_RUN: begin
                modeD = SID_MODE_TEST;
            end
            `SID_IR_TOGGLE_ONLY: begin
                modeD = SID_MODE_TEST;
                captD = SID_CAPT_HOLD;
            end
            `SID_IR_READ_NORMAL: begin
                dregD = SID_DREG_BOUNDARY;
                captD = SID_CAPT_HOLD;
            end
            `SID_IR_READ_TEST: begin
                dregD = SID_DREG_BOUNDARY;
                modeD = SID_MODE_TEST;
                captD = SID_CAPT_HOLD;
            end
            `SID_IR_CELL_CHECK: begin
                dregD = SID_DREG_BOUNDARY;
                captD = SID_CAPT_INVERT;
            end
            `SID_IR_CTRL_SCAN_NORMAL: begin
                dregD = SID_DREG_CONTROL;
                captD = SID_CAPT_HOLD;
            end
            `SID_IR_CTRL_SCAN_TEST: begin
                dregD = SID_DREG_CONTROL;
                modeD = SID_MODE_TEST;
                captD = SID_CAPT_HOLD;
            end
            default: begin
                dregD = SID_DREG_BYPASS;
            end
        endcase
    end

    // Decoded instruction latches together with the instruction shadow
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            selReg <= SID_DREG_BYPASS;
            modeSel <= SID_MODE_NORMAL;
            cellCapture <= SID_CAPT_SAMPLE;
        end else if (testLogicReset) begin
            selReg <= SID_DREG_BYPASS;
            modeSel <= SID_MODE_NORMAL;
            cellCapture <= SID_CAPT_SAMPLE;
        end else if (updateIr) begin
            selReg <= dregD;
            modeSel <= modeD;
            cellCapture <= captD;
        end
    end

    // Operation decode from the control and instruction shadows, the run-idle level and the direction enables
    always_comb begin
        runOpD = SID_OP_IDLE;
        if (runTestIdle && irShadow == `SID_IR_RUN && dirValid) begin
            if (ctrlShadow[`SID_OPSEL_HI:`SID_OPSEL_LO] == `SID_OPSEL_SIG_PATTERN) begin
                runOpD = SID_OP_SIG_PATTERN;
            end else if (ctrlShadow[`SID_OPSEL_HI:`SID_OPSEL_LO] == `SID_OPSEL_SIG_COUNT) begin
                runOpD = SID_OP_SIG_COUNT;
            end else if (ctrlShadow[1:0] == `SID_OPSEL_SAMPLE_TOGGLE) begin
                runOpD = SID_OP_SAMPLE_TOGGLE;
            end else if (ctrlShadow[1:0] == `SID_OPSEL_PATTERN) begin
                runOpD = SID_OP_PATTERN;
            end else begin
                runOpD = SID_OP_SIGNATURE;
            end
        end else if (runTestIdle && irShadow == `SID_IR_TOGGLE_ONLY) begin
            runOpD = SID_OP_TOGGLE_OUT;
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            runOp <= SID_OP_IDLE;
            inputExclude <= '0;
        end else begin
            runOp <= runOpD;
            inputExclude <= ctrlShadow[`SID_MASK_HI:`SID_MASK_LO];
        end
    end

    // Bypass bit has no shadow
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bypassQ <= 1'b0;
        end else if (captureDr && selBypass) begin
            bypassQ <= `SID_BYPASS_CAPT;
        end else if (shiftDr && selBypass) begin
            bypassQ <= tdi;
        end
    end

    // Serial output changes on the falling edge so the controller samples it cleanly
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdoOeN <= 1'b1;
        end else if (shiftIr) begin
            tdo <= irShift[0];
            tdoOeN <= 1'b0;
        end else if (shiftDr) begin
            tdoOeN <= 1'b0;
            if (selReg == SID_DREG_BOUNDARY) begin
                tdo <= boundaryChainOut;
            end else if (selCtrl) begin
                tdo <= ctrlShift[0];
            end else begin
                tdo <= bypassQ;
            end
        end else begin
            tdoOeN <= 1'b1;
        end
    end

    sid_word_cross #(
        .WIDTH(`SID_WORD_WIDTH)
    ) toSys (
        .tck(tck),
        .rst_n(rst_n),
        .wordIn({selReg, modeSel, cellCapture, runOp, inputExclude}),
        .clk(clk),
        .clkEn(clkEn),
        .wordOut(sysWord)
    );

    assign sysSelReg = sid_dreg_e'(sysWord[23:21]);
    assign sysMode = sid_mode_e'(sysWord[20:18]);
    assign sysCapture = sid_capt_e'(sysWord[17:15]);
    assign sysRunOp = sid_runop_e'(sysWord[14:8]);
    assign sysInputExclude = sysWord[7:0];

    // Helper history for the shift check
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ctrlPrevQ <= '0;
            tdiPrevQ <= 1'b0;
        end else begin
            ctrlPrevQ <= ctrlShift;
            tdiPrevQ <= tdi;
        end
    end

    ctrl_reset_a: assert property (@(posedge tck) disable iff (!rst_n)
        testLogicReset |=> ctrlShift == `SID_CTRL_RESET)
        else $error("control register not reset to default");

    ctrl_capture_a: assert property (@(posedge tck) disable iff (!rst_n)
        (captureDr && !shiftDr && !testLogicReset && selCtrl) |=> $stable(ctrlShift))
        else $error("control register changed at capture");

    ctrl_shift_a: assert property (@(posedge tck) disable iff (!rst_n)
        (shiftDr && !captureDr && !testLogicReset && selCtrl) ##1 1'b1 |-> ctrlShift == {tdiPrevQ, ctrlPrevQ[10:1]})
        else $error("control register shift order wrong");

    bypass_capture_a: assert property (@(posedge tck) disable iff (!rst_n)
        (captureDr && !testLogicReset && selBypass) |=> bypassQ == 1'b0)
        else $error("bypass did not capture zero");

    ir_status_a: assert property (@(posedge tck) disable iff (!rst_n)
        (captureIr && !testLogicReset) |=> irShift == `SID_IR_STATUS)
        else $error("instruction status pattern not captured");

    boundary_mode_a: assert property (@(posedge tck) disable iff (!rst_n)
        (irShadow == `SID_IR_EXTEST || irShadow == `SID_IR_INTEST)
        |-> (selReg == SID_DREG_BOUNDARY && modeSel == SID_MODE_TEST))
        else $error("boundary test decode wrong");

    bypass_default_a: assert property (@(posedge tck) disable iff (!rst_n)
        irShadow == `SID_IR_RESET |-> (selReg == SID_DREG_BYPASS && modeSel == SID_MODE_NORMAL))
        else $error("reset instruction not bypass normal");

    highz_mode_a: assert property (@(posedge tck) disable iff (!rst_n)
        irShadow == `SID_IR_HIGHZ |-> (selReg == SID_DREG_BYPASS && modeSel == SID_MODE_MODTEST))
        else $error("float instruction decode wrong");

    run_gate_a: assert property (@(posedge tck) disable iff (!rst_n)
        (runOp != SID_OP_IDLE && runOp != SID_OP_TOGGLE_OUT)
        |-> $past(aSideDriveEnable) != $past(bSideDriveEnable))
        else $error("operation ran with both or no directions");

    sig_select_a: assert property (@(posedge tck) disable iff (!rst_n)
        (runTestIdle && irShadow == `SID_IR_RUN && dirValid && ctrlShadow[1:0] == 2'h2)
        |=> runOp == SID_OP_SIGNATURE)
        else $error("signature operation not selected");

    tdo_drive_a: assert property (@(negedge tck) disable iff (!rst_n)
        (shiftIr || shiftDr) |=> !tdoOeN) else $error("serial output not driven during shift");

    run_count_c: cover property (@(posedge tck) disable iff (!rst_n) runOp == SID_OP_SIG_COUNT);
    ctrl_update_c: cover property (@(posedge tck) disable iff (!rst_n) updateDr && selCtrl);
    cell_check_c: cover property (@(posedge tck) disable iff (!rst_n)
        cellCapture == SID_CAPT_INVERT && captureDr);

endmodule

`default_nettype wire

// ---- dv/sid_tap_master.sv ----
`timescale 1ns/1ns
`default_nettype none

module sid_tap_master (
    // Link clock and serial data
    output logic tck,
    output logic tdi,
    input wire logic tdo,
    // Controller state levels
    output logic testLogicReset,
    output logic runTestIdle,
    output logic captureDr,
    output logic shiftDr,
    output logic updateDr,
    output logic captureIr,
    output logic shiftIr,
    output logic updateIr
);
    localparam int ST_NONE = 0, ST_TLR = 1, ST_RTI = 2, ST_CDR = 3, ST_SDR = 4, ST_UDR = 5, ST_CIR = 6;
    localparam int ST_SIR = 7, ST_UIR = 8;

    int state = ST_TLR;
    int pauseCycles = 0;

    initial begin
        tck = 1'b1;
        tdi = 1'b0;
    end

    assign testLogicReset = state == ST_TLR;
    assign runTestIdle = state == ST_RTI;
    assign captureDr = state == ST_CDR;
    assign shiftDr = state == ST_SDR;
    assign updateDr = state == ST_UDR;
    assign captureIr = state == ST_CIR;
    assign shiftIr = state == ST_SIR;
    assign updateIr = state == ST_UIR;

    // Clock stands high between frames; levels move just after a rising edge
    task automatic step(input int st, input logic d, output logic seen);
        // Wait off the rising edge so the device samples the previous state there
        #1 state = st;
        // Outside shifts the data line flips, so a stale bit never passes for data
        tdi = (st == ST_SIR || st == ST_SDR) ? d : ~tdi;
        #79 tck = 1'b0;
        #80 seen = tdo;
        tck = 1'b1;
    endtask

    task automatic ir_scan(input logic [7:0] code, output logic [7:0] seen);
        logic b;
        step(ST_CIR, 1'b0, b);
        for (int i = 0; i < 8; i++) begin
            step(ST_SIR, code[i], b);
            seen[i] = b;
        end
        step(ST_NONE, 1'b0, b);
        step(ST_UIR, 1'b0, b);
        step(ST_RTI, 1'b0, b);
    endtask

    // A slow controller lingers in pause states before the update
    task automatic dr_scan(input int n, input logic [15:0] data, output logic [15:0] seen);
        logic b;
        seen = '0;
        step(ST_CDR, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(ST_SDR, data[i], b);
            seen[i] = b;
        end
        repeat (pauseCycles + 1) step(ST_NONE, 1'b0, b);
        step(ST_UDR, 1'b0, b);
        step(ST_RTI, 1'b0, b);
    endtask

    task automatic run(input int n);
        logic b;
        repeat (n) step(ST_RTI, 1'b0, b);
    endtask

    task automatic tlr();
        logic b;
        repeat (2) step(ST_TLR, 1'b0, b);
        step(ST_RTI, 1'b0, b);
    endtask
endmodule

`default_nettype wire

// ---- dv/sid_scan_decode_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sid_defines.svh"

module sid_scan_decode_tb
    import sid_pkg::*;
;
    localparam sid_dreg_e BND = SID_DREG_BOUNDARY, BYP = SID_DREG_BYPASS, CTL = SID_DREG_CONTROL;
    localparam sid_mode_e NRM = SID_MODE_NORMAL, TST = SID_MODE_TEST, MOD = SID_MODE_MODTEST;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic boundaryChainOut = 1'b0;
    logic aSideDriveEnable = 1'b1;
    logic bSideDriveEnable = 1'b0;
    logic tck, tdi, tdo, tdoOeN, testLogicReset, runTestIdle;
    logic captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr;
    sid_dreg_e selReg, sysSelReg;
    sid_mode_e modeSel, sysMode;
    sid_capt_e cellCapture, sysCapture;
    sid_runop_e runOp, sysRunOp;
    logic [`SID_MASK_WIDTH-1:0] inputExclude, sysInputExclude;
    logic [15:0] seen;
    int failCount = 0;
    int testsRun = 0;
    int cycles = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    sid_scan_decode u_sid_scan_decode (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .tck(tck), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN),
        .testLogicReset(testLogicReset), .runTestIdle(runTestIdle), .captureDr(captureDr),
        .shiftDr(shiftDr), .updateDr(updateDr), .captureIr(captureIr), .shiftIr(shiftIr),
        .updateIr(updateIr), .boundaryChainOut(boundaryChainOut), .aSideDriveEnable(aSideDriveEnable),
        .bSideDriveEnable(bSideDriveEnable), .selReg(selReg), .modeSel(modeSel),
        .cellCapture(cellCapture), .runOp(runOp), .inputExclude(inputExclude), .sysSelReg(sysSelReg),
        .sysMode(sysMode), .sysCapture(sysCapture), .sysRunOp(sysRunOp), .sysInputExclude(sysInputExclude)
    );

    sid_tap_master u_sid_tap_master (
        .tck(tck), .tdi(tdi), .tdo(tdo), .testLogicReset(testLogicReset), .runTestIdle(runTestIdle),
        .captureDr(captureDr), .shiftDr(shiftDr), .updateDr(updateDr), .captureIr(captureIr),
        .shiftIr(shiftIr), .updateIr(updateIr)
    );

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The crossing answers within five system clocks
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    task automatic load_ir(input logic [7:0] code);
        u_sid_tap_master.ir_scan(code, seen[7:0]);
        check("ir capture", seen[7:0], `SID_IR_STATUS);
        check("tdoOeN released", tdoOeN, 1'b1);
    endtask

    // A capture action of zero means the code leaves it open
    task automatic sel_code(input logic [7:0] code, input sid_dreg_e dreg, input sid_mode_e mode,
                            input logic [2:0] capt);
        load_ir(code);
        check("selReg", selReg, dreg);
        check("modeSel", modeSel, mode);
        if (capt != 3'h0) begin
            check("cellCapture", cellCapture, capt);
        end
        settle();
        check("sysSelReg", sysSelReg, dreg);
        check("sysMode", sysMode, mode);
        if (capt != 3'h0) begin
            check("sysCapture", sysCapture, capt);
        end
    endtask

    task automatic test_reset();
        check("selReg", selReg, BYP);
        check("modeSel", modeSel, NRM);
        check("runOp", runOp, SID_OP_IDLE);
        settle();
        check("sysSelReg", sysSelReg, BYP);
    endtask

    task automatic test_decode();
        sel_code(8'h00, BND, TST, SID_CAPT_SAMPLE);
        sel_code(8'h03, BND, TST, SID_CAPT_SAMPLE);
        sel_code(8'h82, BND, NRM, SID_CAPT_SAMPLE);
        sel_code(8'h81, BYP, NRM, 3'h0);
        sel_code(8'h84, BYP, NRM, 3'h0);
        sel_code(8'h05, BYP, NRM, 3'h0);
        sel_code(8'h88, BYP, NRM, 3'h0);
        sel_code(8'h90, BYP, NRM, 3'h0);
        sel_code(8'h06, BYP, MOD, 3'h0);
        sel_code(8'h87, BYP, TST, 3'h0);
        sel_code(8'h09, BYP, TST, 3'h0);
        sel_code(8'h0A, BND, NRM, SID_CAPT_HOLD);
        sel_code(8'h8B, BND, TST, SID_CAPT_HOLD);
        sel_code(8'h0C, BND, NRM, SID_CAPT_INVERT);
        sel_code(8'h8D, BYP, TST, SID_CAPT_HOLD);
        sel_code(8'h8E, CTL, NRM, 3'h0);
        sel_code(8'h0F, CTL, TST, 3'h0);
    endtask

    task automatic test_paths();
        load_ir(8'hFF);
        u_sid_tap_master.dr_scan(2, 16'h0001, seen);
        check("bypass out", seen, 16'h0002);
        load_ir(8'h82);
        @(posedge clk);
        boundaryChainOut <= 1'b1;
        u_sid_tap_master.dr_scan(3, 16'h0000, seen);
        check("chain out", seen, 16'h0007);
        load_ir(8'h8E);
        u_sid_tap_master.dr_scan(11, 16'h05A9, seen);
        check("control reset", seen, 16'h0002);
        u_sid_tap_master.pauseCycles = 3;
        u_sid_tap_master.dr_scan(11, 16'h0103, seen);
        check("control readback", seen, 16'h05A9);
        u_sid_tap_master.pauseCycles = 0;
    endtask

    task automatic test_run();
        logic [7:0] mask;
        logic [2:0] opc [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        sid_runop_e want [8] = '{SID_OP_SAMPLE_TOGGLE, SID_OP_SAMPLE_TOGGLE, SID_OP_PATTERN,
            SID_OP_PATTERN, SID_OP_SIGNATURE, SID_OP_SIGNATURE, SID_OP_SIG_PATTERN, SID_OP_SIG_COUNT};
        for (int i = 0; i < 8; i++) begin
            mask = 8'h01 << i;
            @(posedge clk);
            aSideDriveEnable <= i[0];
            bSideDriveEnable <= ~i[0];
            load_ir(8'h8E);
            u_sid_tap_master.dr_scan(11, {5'h00, mask, opc[i]}, seen);
            load_ir(8'h09);
            u_sid_tap_master.run(2);
            check("runOp", runOp, want[i]);
            check("inputExclude", inputExclude, mask);
            settle();
            check("sysRunOp", sysRunOp, want[i]);
            check("sysInputExclude", sysInputExclude, mask);
        end
        @(posedge clk);
        bSideDriveEnable <= aSideDriveEnable;
        u_sid_tap_master.run(2);
        check("runOp both sides", runOp, SID_OP_IDLE);
        @(posedge clk);
        bSideDriveEnable <= ~aSideDriveEnable;
        load_ir(8'h8D);
        u_sid_tap_master.run(2);
        check("runOp toggle", runOp, SID_OP_TOGGLE_OUT);
    endtask

    task automatic test_tlr();
        load_ir(8'h0F);
        u_sid_tap_master.dr_scan(11, 16'h07FF, seen);
        check("control held", seen, 16'h0407);
        u_sid_tap_master.tlr();
        check("selReg after tlr", selReg, BYP);
        check("modeSel after tlr", modeSel, NRM);
        load_ir(8'h8E);
        u_sid_tap_master.dr_scan(11, 16'h0000, seen);
        check("control after tlr", seen, 16'h0002);
        // Only the mode changes here, so a frozen receiver must still show normal
        @(posedge clk);
        clkEn <= 1'b0;
        load_ir(8'h0F);
        settle();
        check("sysMode frozen", sysMode, NRM);
        @(posedge clk);
        clkEn <= 1'b1;
        settle();
        check("sysMode released", sysMode, TST);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failCount++;
            reportAndStop();
        end
    end

    initial begin
        fork
            u_sid_tap_master.tlr();
            begin
                repeat (12) @(posedge clk);
                rst_n <= 1'b1;
            end
        join
        test_reset();
        test_decode();
        test_paths();
        test_run();
        test_tlr();
        reportAndStop();
    end
endmodule

`default_nettype wire
